// *** host_fabric_model.sv ***
`timescale 1ns/1ps
// far side: highway timing, receive data, bus timing; captures tx lanes in highway frames
module host_fabric_model (
  // mode and payload
  input  wire logic       gci_on,
  input  wire logic [7:0] rx_byte,
  input  wire logic       tx_bit,
  input  wire logic       tx_en,
  // pins toward the device, and the captured lane word
  output logic            bit_clk,
  output logic            frame_sync,
  output logic            rx_bit,
  output logic [15:0]     tx_word
);
  int          n;    // bit index in frame
  int          len;  // bits per frame
  logic        g;    // mode latched per frame
  logic [15:0] sh;   // captured lane bits
  // free-running link, 3 ns offset keeps it off the system edges
  initial begin
    {bit_clk, frame_sync, rx_bit, tx_word, sh} = '0;
    #3;
    forever begin
      g   = gci_on;
      len = g ? 256 : 32;
      for (n = 0; n < len; n++) begin
        if (g) begin
          // one sync pulse, then a data clock per bit
          bit_clk    = (n == 0);
          frame_sync = 1'b1;
          rx_bit     = n[0];
          #40;
          frame_sync = 1'b0;
          #40;
        end else begin
          // lane bits launched earlier are settled at this rise
          if (tx_en) sh = {sh[14:0], tx_bit};
          if (n == 16) tx_word = sh;
          bit_clk = 1'b1;
          // outside the slot the line toggles every bit
          rx_bit  = (n < 8) ? rx_byte[7-n] : n[0];
          #40;
          bit_clk    = 1'b0;
          frame_sync = (n == 31);
          #40;
        end
      end
    end
  end
endmodule

// *** pair_buffer.sv ***
`timescale 1ns/1ps
// small shift-style buffer; head word, valid and ready all come from flops
module pair_buffer
  import vhi_pkg::*;
#(
  parameter int W     = 32,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  if (DEPTH < 2 || DEPTH > 8) begin : g_bad_depth
    $error("pair_buffer depth must be 2 to 8");
  end

  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_r   [DEPTH];        // entry 0 is the head
  logic [W-1:0]  mem_nxt [DEPTH];
  logic [CW-1:0] cnt_r;                  // words held
  logic [CW-1:0] cnt_nxt;
  logic          full_r;
  logic          empty_r;
  logic          push;
  logic          pop;
  logic [CW-1:0] wr_at;

  assign push      = in_valid && !full_r;
  assign pop       = out_ready && !empty_r;
  assign in_ready  = !full_r;
  assign out_valid = !empty_r;
  assign out_data  = mem_r[0];

  // next contents: shift on pop, then write behind the last word
  always_comb begin
    cnt_nxt = cnt_r;
    wr_at   = pop ? CW'(cnt_r - 1'b1) : cnt_r;
    for (int i = 0; i < DEPTH; i++) begin
      mem_nxt[i] = (pop && i < DEPTH - 1) ? mem_r[i + 1] : mem_r[i];
    end
    if (push) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (CW'(i) == wr_at) begin
          mem_nxt[i] = in_data;
        end
      end
    end
    if (push && !pop) begin
      cnt_nxt = CW'(cnt_r + 1'b1);
    end else if (pop && !push) begin
      cnt_nxt = CW'(cnt_r - 1'b1);
    end
  end

  // storage and flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r   <= '0;
      full_r  <= 1'b0;
      empty_r <= 1'b1;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      cnt_r   <= cnt_nxt;
      full_r  <= (cnt_nxt == CW'(DEPTH));
      empty_r <= (cnt_nxt == '0);
      mem_r   <= mem_nxt;
    end
  end

endmodule

// *** vhi_pkg.sv ***
package vhi_pkg;

  // system clock
  localparam int CLK_PERIOD_NS = 10;          // 100 MHz sampling clock

  // frame and bus geometry
  localparam int FRAME_HZ       = 8000;       // nominal frame rate, informative only
  localparam int BIT_CNT_W      = 10;         // up to 1024 bit periods per frame
  localparam int SLOT_BITS      = 8;          // one timeslot step in bit periods
  localparam int GCI_CHAN_BITS  = 32;         // four bytes per bus channel
  localparam int GCI_PAIR_BITS  = 64;         // two bus channels in single-bearer mode
  localparam int GCI_B2_OFS     = 8;          // second bearer byte within a channel
  localparam int GCI_CTL_OFS    = 16;         // monitor byte, then signalling byte
  localparam int GCI_CTL_LEN    = 16;         // monitor + signalling bits
  localparam int GCI_ENTRY_CLKS = 48;         // data clocks per frame that mean bus mode
  localparam int CTL_BYTE_BITS  = 8;          // control port byte length
  localparam int DET_CNT_W      = 6;          // detector counter width

  // control port chip-select off time
  localparam int CS_OFF_NS  = 200;
  localparam int CS_OFF_CYC = (CS_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // bits per channel per frame
  localparam logic [4:0] LEN_COMPANDED = 5'h08;
  localparam logic [4:0] LEN_ADPCM32   = 5'h04;
  localparam logic [4:0] LEN_ADPCM24   = 5'h03;
  localparam logic [4:0] LEN_LINEAR    = 5'h10;

  // voice sample formats
  typedef enum logic [1:0] {
    FMT_COMPANDED,
    FMT_ADPCM32,
    FMT_ADPCM24,
    FMT_LINEAR
  } sample_fmt_e;

  // digital interface mode
  typedef enum logic {
    MODE_HIGHWAY,
    MODE_GCI
  } bus_mode_e;

  localparam bus_mode_e MODE_RESET = MODE_HIGHWAY;

  // one frame of voice, both channels, left-justified
  typedef struct packed {
    logic [15:0] ch0;
    logic [15:0] ch1;
  } voice_pair_s;

  // monitor and signalling content of one bus channel
  typedef struct packed {
    logic [7:0] mon;
    logic [5:0] ci;
    logic       mr;
    logic       mx;
  } gci_ctl_s;

endpackage

// *** voice_host_interface_select.sv ***
`timescale 1ns/1ps
module voice_host_interface_select
  import vhi_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // voice highway pins (bit clock pin carries bus sync, sync pin carries data clock)
  input  wire logic        highway_bit_clock,
  input  wire logic        highway_frame_sync,
  input  wire logic        highway_rx_data,
  output logic             highway_tx_data,
  output logic             slot_drive_enable_out,
  // control port pins, shared with channel straps
  input  wire logic        control_shift_clock,
  input  wire logic        ctl_cs_n,
  input  wire logic        ctl_din,
  output logic             ctl_dout,
  output logic             ctl_dout_oe,
  input  wire logic        channel_strap_bit2,
  input  wire logic        bus_mode_strap,
  // configuration
  input  wire sample_fmt_e sample_format,
  input  wire logic        edge_select_bit,
  input  wire logic [2:0]  clock_slot,
  input  wire logic [6:0]  timeslot_ch0,
  input  wire logic [6:0]  timeslot_ch1,
  input  wire logic        ctl_reply_enable,
  input  wire logic [7:0]  ctl_reply,
  input  wire logic        overrun_clear,
  // voice toward the line
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire voice_pair_s tx_data,
  // voice from the line
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output voice_pair_s      rx_data,
  output logic             rx_overrun,
  // bus monitor and signalling
  input  wire gci_ctl_s    gci_tx,
  output gci_ctl_s         gci_rx,
  // control bytes and status
  output logic             ctl_byte_valid,
  output logic [7:0]       ctl_byte,
  output logic             gci_mode
);

  localparam int NP = 7;                 // synchronised pins
  localparam int NL = 3;                 // lanes: ch0, ch1, bus control

  // pin synchronisers: three stages, a change counts once stages 2 and 3 agree
  logic [NP-1:0] pin_raw;
  logic [NP-1:0] s1_r, s2_r, s3_r;
  logic [NP-1:0] filt_r, filt_nxt;
  logic [NP-1:0] prev_r;
  logic [NP-1:0] rise, fall;

  assign pin_raw  = {channel_strap_bit2, ctl_din, ctl_cs_n, control_shift_clock,
                     highway_rx_data, highway_frame_sync, highway_bit_clock};
  assign filt_nxt = (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));
  assign rise     = filt_r & ~prev_r;
  assign fall     = ~filt_r & prev_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r   <= 7'h18;                   // all stages start at the idle levels,
      s2_r   <= 7'h18;                   // else a false select edge follows reset
      s3_r   <= 7'h18;
      filt_r <= 7'h18;                   // select and clock idle high
      prev_r <= 7'h18;
    end else begin
      s1_r   <= pin_raw;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      filt_r <= filt_nxt;
      prev_r <= filt_r;
    end
  end

  // filtered pin roles
  logic bclk_pin_rise, sync_pin_rise, sync_pin_fall, bclk_pin_fall;
  logic rx_bit, control_shift_clock_rise, control_shift_clock_fall, cs_low, cs_rise, cs_fall, din_bit;
  assign bclk_pin_rise = rise[0];
  assign bclk_pin_fall = fall[0];
  assign sync_pin_rise = rise[1];
  assign sync_pin_fall = fall[1];
  assign rx_bit        = filt_r[2];
  assign control_shift_clock_rise     = rise[3];
  assign control_shift_clock_fall     = fall[3];
  assign cs_low        = !filt_r[4];
  assign cs_rise       = rise[4];
  assign cs_fall       = fall[4];
  assign din_bit       = filt_r[5];

  // mode detection
  bus_mode_e            mode_r, mode_nxt;
  logic [DET_CNT_W-1:0] det_r, det_nxt;     // data clocks since last bus sync
  logic [3:0]           bits_r, bits_nxt;   // control bits this select period
  logic                 exit_hit;

  assign exit_hit = (mode_r == MODE_GCI) && cs_low && control_shift_clock_rise
                    && (bits_r == 4'(CTL_BYTE_BITS - 1));

  always_comb begin
    mode_nxt = mode_r;
    det_nxt  = det_r;
    if (exit_hit) begin
      mode_nxt = MODE_HIGHWAY;
      det_nxt  = '0;
    end else if (mode_r == MODE_HIGHWAY) begin
      if (bclk_pin_rise) begin
        // bit clock pin rising is the bus sync when the bus is wired
        if (det_r >= DET_CNT_W'(GCI_ENTRY_CLKS)) begin
          mode_nxt = MODE_GCI;
        end
        det_nxt = '0;
      end else if (sync_pin_rise && det_r != '1) begin
        det_nxt = DET_CNT_W'(det_r + 1'b1);
      end
    end else begin
      det_nxt = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= MODE_RESET;
      det_r  <= '0;
    end else begin
      mode_r <= mode_nxt;
      det_r  <= det_nxt;
    end
  end

  // control port
  logic [7:0] in_sh_r, in_sh_nxt;        // keeps the last eight bits
  logic [7:0] out_sh_r, out_sh_nxt;
  logic [7:0] off_r, off_nxt;            // off time still to run
  logic       bad_r, bad_nxt;            // period opened too soon
  logic       bv_nxt;
  logic [7:0] byte_nxt;

  always_comb begin
    in_sh_nxt  = in_sh_r;
    out_sh_nxt = out_sh_r;
    bits_nxt   = bits_r;
    off_nxt    = off_r;
    bad_nxt    = bad_r;
    bv_nxt     = 1'b0;
    byte_nxt   = ctl_byte;
    if (!cs_low && off_r != '0) begin
      off_nxt = 8'(off_r - 1'b1);
    end
    if (cs_fall) begin
      bits_nxt   = '0;
      bad_nxt    = (off_r != '0);
      out_sh_nxt = ctl_reply;
    end else if (cs_low) begin
      if (control_shift_clock_rise) begin
        in_sh_nxt = {in_sh_r[6:0], din_bit};
        if (bits_r != 4'(CTL_BYTE_BITS)) begin
          bits_nxt = 4'(bits_r + 1'b1);
        end
      end
      if (control_shift_clock_fall) begin
        out_sh_nxt = {out_sh_r[6:0], 1'b0};
      end
    end
    if (cs_rise) begin
      off_nxt = 8'(CS_OFF_CYC);
      // fewer than eight bits, or a rushed select, is dropped
      if (bits_r == 4'(CTL_BYTE_BITS) && !bad_r) begin
        bv_nxt   = 1'b1;
        byte_nxt = in_sh_r;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_sh_r        <= '0;
      out_sh_r       <= '0;
      bits_r         <= '0;
      off_r          <= '0;
      bad_r          <= 1'b0;
      ctl_byte_valid <= 1'b0;
      ctl_byte       <= '0;
      ctl_dout       <= 1'b0;
      ctl_dout_oe    <= 1'b0;
    end else begin
      in_sh_r        <= in_sh_nxt;
      out_sh_r       <= out_sh_nxt;
      bits_r         <= bits_nxt;
      off_r          <= off_nxt;
      bad_r          <= bad_nxt;
      ctl_byte_valid <= bv_nxt;
      ctl_byte       <= byte_nxt;
      ctl_dout       <= out_sh_nxt[7];
      ctl_dout_oe    <= cs_low && ctl_reply_enable && (mode_r == MODE_HIGHWAY);
    end
  end

  // serial voice engine
  logic                 frame_rise, launch, sample;
  logic [2:0]           strap;
  logic [BIT_CNT_W-1:0] base;
  logic [4:0]           fmt_len;
  logic [BIT_CNT_W-1:0] start [NL];
  logic [4:0]           len   [NL];
  logic                 en    [NL];
  logic [15:0]          word_r [NL], word_nxt [NL];
  logic [15:0]          rsh_r  [NL], rsh_nxt  [NL];
  logic [BIT_CNT_W-1:0] cnt_r, cnt_nxt, idx, diff;
  logic [1:0]           lane_r, lane_nxt;   // lane of last launched bit, 3 is none
  logic                 txb_nxt, oe_nxt, seen_r, ovr_nxt;
  logic                 tb_valid, tb_pop, rb_ready;
  voice_pair_s          tb_data, rb_data;
  gci_ctl_s             grx_nxt;

  // highway: bit clock on its pin; bus: data clock on the sync pin
  assign frame_rise = gci_mode ? bclk_pin_rise : sync_pin_rise;
  assign launch = gci_mode ? (edge_select_bit ? sync_pin_rise : sync_pin_fall)
                           : (edge_select_bit ? bclk_pin_rise : bclk_pin_fall);
  assign sample = gci_mode ? (edge_select_bit ? sync_pin_fall : sync_pin_rise)
                           : (edge_select_bit ? bclk_pin_fall : bclk_pin_rise);
  assign strap  = {filt_r[6], filt_r[5], filt_r[3]};
  assign tb_pop = frame_rise;

  always_comb begin
    case (sample_format)
      FMT_COMPANDED: fmt_len = LEN_COMPANDED;
      FMT_ADPCM32:   fmt_len = LEN_ADPCM32;
      FMT_ADPCM24:   fmt_len = LEN_ADPCM24;
      FMT_LINEAR:    fmt_len = LEN_LINEAR;
      default:       fmt_len = LEN_COMPANDED;
    endcase
    // single bearer ignores the top strap and takes a channel pair
    base = bus_mode_strap ? BIT_CNT_W'(strap[1:0] * GCI_PAIR_BITS)
                          : BIT_CNT_W'(strap * GCI_CHAN_BITS);
    if (!gci_mode) begin
      start[0] = BIT_CNT_W'(clock_slot) + BIT_CNT_W'(timeslot_ch0 * SLOT_BITS);
      start[1] = BIT_CNT_W'(clock_slot) + BIT_CNT_W'(timeslot_ch1 * SLOT_BITS);
      len[0]   = fmt_len;
      len[1]   = fmt_len;
      en[2]    = 1'b0;
    end else begin
      start[0] = base;
      start[1] = bus_mode_strap ? BIT_CNT_W'(base + GCI_CHAN_BITS)
                                : BIT_CNT_W'(base + GCI_B2_OFS);
      len[0]   = (bus_mode_strap || fmt_len < LEN_COMPANDED) ? fmt_len : LEN_COMPANDED;
      len[1]   = len[0];
      en[2]    = 1'b1;
    end
    start[2] = BIT_CNT_W'(base + GCI_CTL_OFS);
    len[2]   = 5'(GCI_CTL_LEN);
    en[0]    = 1'b1;
    en[1]    = 1'b1;
  end

  // frame counter, lane hit, shifters
  always_comb begin
    idx      = frame_rise ? '0 : cnt_r;
    cnt_nxt  = idx;
    lane_nxt = lane_r;
    txb_nxt  = highway_tx_data;
    oe_nxt   = slot_drive_enable_out;
    diff     = '0;
    ovr_nxt  = rx_overrun && !overrun_clear;
    for (int k = 0; k < NL; k++) begin
      word_nxt[k] = word_r[k];
      rsh_nxt[k]  = rsh_r[k];
    end
    if (frame_rise) begin
      word_nxt[0] = tb_valid ? tb_data.ch0 : 16'h0000;
      word_nxt[1] = tb_valid ? tb_data.ch1 : 16'h0000;
      word_nxt[2] = gci_tx;
      for (int k = 0; k < NL; k++) begin
        rsh_nxt[k] = '0;
      end
      if (seen_r && !rb_ready) begin
        ovr_nxt = 1'b1;                                         // set wins over clear
      end
      lane_nxt = 2'h3;
    end
    if (launch) begin
      txb_nxt  = 1'b0;
      oe_nxt   = 1'b0;
      lane_nxt = 2'h3;
      for (int k = 0; k < NL; k++) begin
        diff = BIT_CNT_W'(idx - start[k]);
        if (en[k] && idx >= start[k] && diff < BIT_CNT_W'(len[k])) begin
          txb_nxt  = word_nxt[k][4'hf - diff[3:0]];
          oe_nxt   = 1'b1;
          lane_nxt = 2'(k);
        end
      end
      if (idx != '1) begin
        cnt_nxt = BIT_CNT_W'(idx + 1'b1);
      end
    end
    if (sample && lane_r != 2'h3) begin
      for (int k = 0; k < NL; k++) begin
        if (lane_r == 2'(k)) begin
          rsh_nxt[k] = {rsh_r[k][14:0], rx_bit};
        end
      end
    end
  end

  // frame word for the receive buffer, left-justified like transmit
  assign rb_data.ch0 = rsh_r[0] << (5'h10 - len[0]);
  assign rb_data.ch1 = rsh_r[1] << (5'h10 - len[1]);
  assign grx_nxt     = rsh_r[2];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r                 <= '0;
      lane_r                <= 2'h3;
      seen_r                <= 1'b0;
      highway_tx_data       <= 1'b0;
      slot_drive_enable_out <= 1'b0;
      rx_overrun            <= 1'b0;
      gci_rx                <= '0;
      gci_mode              <= 1'b0;
      for (int k = 0; k < NL; k++) begin
        word_r[k] <= '0;
        rsh_r[k]  <= '0;
      end
    end else begin
      cnt_r                 <= cnt_nxt;
      lane_r                <= lane_nxt;
      seen_r                <= seen_r || frame_rise;
      highway_tx_data       <= txb_nxt;
      slot_drive_enable_out <= oe_nxt;
      rx_overrun            <= ovr_nxt;
      gci_mode              <= (mode_nxt == MODE_GCI);
      if (frame_rise && seen_r) begin
        gci_rx <= grx_nxt;
      end
      word_r <= word_nxt;
      rsh_r  <= rsh_nxt;
    end
  end

  // voice toward the line: drained once per frame
  pair_buffer #(.W(32), .DEPTH(2)) u_tx_buf (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (tb_valid),
    .out_ready (tb_pop),
    .out_data  (tb_data)
  );

  // voice from the line: a stalled reader holds up to two frames
  pair_buffer #(.W(32), .DEPTH(2)) u_rx_buf (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (frame_rise && seen_r),
    .in_ready  (rb_ready),
    .in_data   (rb_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  // checks
  chk_reset_mode: assert property (@(posedge clk) $rose(rst_n) |-> mode_r == MODE_HIGHWAY)
    else $error("mode not highway after reset");
  chk_gci_entry: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_r == MODE_HIGHWAY && bclk_pin_rise && !exit_hit && det_r >= 6'h30)
      |=> mode_r == MODE_GCI ##1 gci_mode)
    else $error("bus mode not entered");
  chk_no_entry: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_r == MODE_HIGHWAY && bclk_pin_rise && det_r < 6'h30) |=> mode_r == MODE_HIGHWAY)
    else $error("bus mode entered too early");
  chk_gci_exit: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_r == MODE_GCI && cs_low && control_shift_clock_rise && bits_r == 4'h7) |=> mode_r == MODE_HIGHWAY)
    else $error("bus mode not left");
  chk_det_restart: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_r != $past(mode_r)) |-> det_r == '0)
    else $error("detector not restarted");
  chk_short_drop: assert property (@(posedge clk) disable iff (!rst_n)
    (cs_rise && bits_r < 4'h8) |=> !ctl_byte_valid)
    else $error("short byte delivered");
  chk_byte_deliver: assert property (@(posedge clk) disable iff (!rst_n)
    (cs_rise && bits_r == 4'h8 && !bad_r) |=> ctl_byte_valid && ctl_byte == $past(in_sh_r))
    else $error("byte not delivered");
  chk_idle_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (!cs_low && !$past(cs_low)) |-> $stable(in_sh_r) && $stable(bits_r))
    else $error("bits moved with select high");
  chk_frame_start: assert property (@(posedge clk) disable iff (!rst_n)
    (frame_rise && !launch) |=> cnt_r == '0)
    else $error("frame counter not restarted");
  chk_slot_place: assert property (@(posedge clk) disable iff (!rst_n)
    (!gci_mode && launch && !frame_rise && cnt_r == start[0] && cnt_r != start[1])
      |=> slot_drive_enable_out && highway_tx_data == $past(word_r[0][15]))
    else $error("first channel bit misplaced");

endmodule

// *** voice_host_interface_select_test.sv ***
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin miscompares++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module voice_host_interface_select_test;
  import vhi_pkg::*;
  // clock, reset, counters
  logic        clk = 1'b0, rst_n = 1'b0;
  int          miscompares = 0, num_checks = 0, cycles = 0;
  // pins and host controls
  logic        bclk, fsync, rxd, txd, txen, dout, dout_oe;
  logic        sclk = 1'b1, cs_n = 1'b1, din = 1'b0, gci_on = 1'b0;
  logic        rx_ready = 1'b1, ov_clr = 1'b0, tx_valid = 1'b1, edge_sel = 1'b1;
  logic        reply_en = 1'b1;
  logic [7:0]  reply = 8'h96;
  logic [6:0]  ts1 = 7'h01;
  voice_pair_s tx_data = {16'hc300, 16'h3c00};
  gci_ctl_s    gci_tx = '0;
  // device outputs, and the lane word captured by the model
  logic        tx_ready, rx_valid, rx_overrun, byte_valid, gci_mode;
  logic [15:0] tx_word;
  logic [7:0]  ctl_byte;
  voice_pair_s rx_data;
  gci_ctl_s    gci_rx;

  always #5 clk = ~clk;

  voice_host_interface_select i_voice_host_interface_select (
    .clk(clk), .rst_n(rst_n), .highway_bit_clock(bclk), .highway_frame_sync(fsync),
    .highway_rx_data(rxd), .highway_tx_data(txd), .slot_drive_enable_out(txen),
    .control_shift_clock(sclk), .ctl_cs_n(cs_n), .ctl_din(din), .ctl_dout(dout),
    .ctl_dout_oe(dout_oe), .channel_strap_bit2(1'b0), .bus_mode_strap(1'b0),
    .sample_format(FMT_COMPANDED), .edge_select_bit(edge_sel), .clock_slot(3'h0),
    .timeslot_ch0(7'h00), .timeslot_ch1(ts1), .ctl_reply_enable(reply_en),
    .ctl_reply(reply), .overrun_clear(ov_clr), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .rx_overrun(rx_overrun), .gci_tx(gci_tx), .gci_rx(gci_rx),
    .ctl_byte_valid(byte_valid), .ctl_byte(ctl_byte), .gci_mode(gci_mode));

  host_fabric_model i_host_fabric_model (
    .gci_on(gci_on), .rx_byte(8'h5a), .tx_bit(txd), .tx_en(txen),
    .bit_clk(bclk), .frame_sync(fsync), .rx_bit(rxd), .tx_word(tx_word));

  // hang guard, well above the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // k clock edges, then a fixed small skew
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // one select period of nb bits, msb first; clock idles high
  task automatic ctl_send(input logic [15:0] v, input int nb, input logic [7:0] ex);
    logic [7:0] rd;
    logic       got, hw;
    rd  = '0;
    got = 1'b0;
    hw  = !gci_mode;
    cs_n = 1'b0;
    cyc(6);
    for (int i = nb - 1; i >= 0; i--) begin
      if (i == nb - 1) `CHK("dout_oe", hw && reply_en, dout_oe)
      din  = v[i];
      rd   = {rd[6:0], dout};
      sclk = 1'b0;
      cyc(6);
      sclk = 1'b1;
      cyc(6);
    end
    cs_n = 1'b1;
    for (int i = 0; i < 20 && !got; i++) begin
      cyc(1);
      got = (byte_valid === 1'b1);
    end
    cyc(CS_OFF_CYC);
    `CHK("byte_valid", (nb >= 8), got)
    if (nb >= 8) `CHK("ctl_byte", ex, ctl_byte)
    if (nb == 8 && hw) `CHK("reply", reply, rd)
  endtask

  // highway lanes both ways, then a receiver stall
  task automatic highway_run();
    cyc(1000);
    `CHK("tx lanes", 16'hc33c, tx_word)
    for (int i = 0; i < 400 && rx_valid !== 1'b1; i++) cyc(1);
    `CHK("rx ch0", 8'h5a, rx_data.ch0[15:8])
    `CHK("rx ch1", 8'h55, rx_data.ch1[15:8])
    cyc(1);
    rx_ready = 1'b0;
    cyc(1200);
    `CHK("overrun", 1'b1, rx_overrun)
    `CHK("held word", 1'b1, rx_valid)
    rx_ready = 1'b1;
    ov_clr   = 1'b1;
    cyc(2);
    ov_clr = 1'b0;
    cyc(2);
    `CHK("overrun clear", 1'b0, rx_overrun)
    edge_sel = 1'b0;
    cyc(600);
    for (int i = 0; i < 400 && rx_valid !== 1'b1; i++) cyc(1);
    `CHK("rx ch0 rise edge", 8'h5a, rx_data.ch0[15:8])
    `CHK("rx ch1 rise edge", 8'h55, rx_data.ch1[15:8])
    edge_sel = 1'b1;
  endtask

  // bus entry by clock count, exit by a control byte
  task automatic bus_run();
    gci_on = 1'b1;
    for (int i = 0; i < 6000 && gci_mode !== 1'b1; i++) cyc(1);
    `CHK("enter bus", 1'b1, gci_mode)
    cyc(2100);
    `CHK("bus ctl lane", 16'h5555, gci_rx)
    gci_on = 1'b0;
    cyc(2200);
    `CHK("short frames", 1'b1, gci_mode)
    ctl_send(16'h0081, 8, 8'h81);
    `CHK("leave bus", 1'b0, gci_mode)
    cyc(1000);
    `CHK("stay highway", 1'b0, gci_mode)
  endtask

  // main sequence
  initial begin
    cyc(6);
    rst_n = 1'b1;
    cyc(4);
    `CHK("power-up mode", 1'b0, gci_mode)
    `CHK("tx_ready full", 1'b0, tx_ready)
    ctl_send(16'h00a5, 8, 8'ha5);
    ctl_send(16'h02c3, 10, 8'hc3);
    ctl_send(16'h001b, 5, 8'hc3);
    highway_run();
    bus_run();
    summarize();
  end
endmodule
